// ===== adc_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.svh"

module adc_clk_div (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic enable_in,
	input wire logic restart_in,
	input wire logic [2:0] div_sel_in,
	output logic tick_out
);
	// ----------------------------------------
	// prescaler: one tick per 2**sel cycles
	// ----------------------------------------
	logic [6:0] cnt_q; // cycles since last tick
	logic [6:0] cnt_d;
	logic [6:0] mask; // terminal count

	// terminal count is 2**sel - 1; sel 0 ticks every cycle
	assign mask = 7'(({1'b0, 7'h7f}) >> (3'h7 - div_sel_in)); // see R4
	assign tick_out = enable_in && !restart_in && (cnt_q == mask); // see R4

	// next count; restart aligns the first tick to the start
	always_comb begin
		if (!enable_in || restart_in || tick_out) begin
			cnt_d = 7'h00;
		end else begin
			cnt_d = cnt_q + 7'h01;
		end
	end

	// count register
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_q <= 7'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);

	logic [7:0] gap_q; // cycles since last tick, for the check
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			gap_q <= 8'h00;
		end else if (tick_out || restart_in || !enable_in) begin
			gap_q <= 8'h00;
		end else begin
			gap_q <= gap_q + 8'h01;
		end
	end

	tick_period_a: assert property ( // see R4
		tick_out && $stable(div_sel_in) |-> gap_q == {1'b0, mask})
		else $error("a/d clock tick spacing wrong");
endmodule
`default_nettype wire

// ===== adc_conversion_sequencer.sv
// Contract
// R1 - 4 sample then 12 convert clock periods
// R2 - conversion runs without processor help
// R3 - software sets clock divider first
// R4 - a/d clock is sysclk over two-power
// R5 - software powers on, waits, then starts
// R6 - park channel before picking internal source
// R7 - source and channel codes route input
// R8 - software picks reference before start
// R9 - reference 01 is avdd, else pin
// R10 - software picks result byte format
// R11 - software enables both interrupt bits
// R12 - start rise resets, fall begins sampling
// R13 - busy high during conversion, results at end
// R14 - completion sets flag, software clears it
// R15 - power off stops all converter activity
// R16 - 12-bit result, full scale fff
// R17 - transitions half step low, last 1.5
// R18 - software may poll busy instead
// R19 - restart aborts run, busy stays high
// R20 - format 0 left, 1 right justified
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.svh"

module adc_conversion_sequencer (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic [2:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic [127:0] ext_analog_inputs_in,
	input wire logic [15:0] bandgap_voltage_in,
	input wire logic [15:0] avdd_level_in,
	input wire logic [15:0] vref_pin_in,
	output logic [7:0] ext_chan_route_out,
	output logic conv_busy_flag_out,
	output logic conv_irq_req_out,
	output logic adc_power_en_out
);
	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	logic [3:0] ext_chan_sel_q, ext_chan_sel_d; // channel code
	logic adc_power_en_q, adc_power_en_d; // converter power
	logic result_format_sel_q, result_format_sel_d; // byte layout
	logic start_q, start_d; // start bit as last written
	logic [2:0] adc_clk_div_sel_q, adc_clk_div_sel_d; // a/d clock divider
	logic [2:0] input_src_sel_q, input_src_sel_d; // input source
	logic [1:0] vref_src_sel_q, vref_src_sel_d; // reference source
	logic conv_irq_en_q, conv_irq_en_d; // a/d interrupt enable
	logic global_irq_en_q, global_irq_en_d; // global interrupt enable

	// ----------------------------------------
	// sequencer state
	// ----------------------------------------
	adc_seq_pkg::conv_state_e state_q, state_d;
	logic [3:0] phase_cnt_q, phase_cnt_d; // a/d clocks in current phase
	logic conv_busy_flag_q, conv_busy_flag_d;
	logic conv_irq_flag_q, conv_irq_flag_d;
	adc_seq_pkg::level_t sample_q, sample_d; // held input level
	adc_seq_pkg::result_t result_q, result_d; // last finished code
	logic [7:0] rdata_q, rdata_d;
	logic irq_req_q, irq_req_d;

	// ----------------------------------------
	// decoded strobes
	// ----------------------------------------
	logic wr_first, wr_irq; // writes to the two live registers
	logic start_rise, start_fall; // start bit edges from software
	logic tick; // one a/d clock period elapsed
	logic running; // sample or convert phase
	logic done; // last convert tick
	adc_seq_pkg::level_t chan_v [8]; // unpacked external levels
	adc_seq_pkg::level_t sel_v; // level at converter input
	adc_seq_pkg::level_t vref_v; // active reference level

	assign wr_first = reg_wr_in && (reg_addr_in == `ADDR_CTRL_FIRST);
	assign wr_irq = reg_wr_in && (reg_addr_in == `ADDR_IRQ_CTRL);
	assign start_rise = wr_first && reg_wdata_in[`F1_START] && !start_q;
	assign start_fall = wr_first && !reg_wdata_in[`F1_START] && start_q;
	assign running = (state_q == adc_seq_pkg::ST_SAMPLE)
		|| (state_q == adc_seq_pkg::ST_CONVERT);
	assign done = tick && (state_q == adc_seq_pkg::ST_CONVERT)
		&& (phase_cnt_q == `CONV_TICKS - 4'h1);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// true when the source code routes the external channel
	function automatic logic src_is_ext(input logic [2:0] src);
		src_is_ext = (src == 3'h0) || (src >= 3'h5); // see R7
	endfunction

	// one result byte in the chosen layout
	function automatic logic [7:0] fmt_byte(input adc_seq_pkg::result_t r,
		input logic right, input logic high);
		if (!right) begin
			fmt_byte = high ? r[11:4] : {r[3:0], 4'h0}; // see R20
		end else begin
			fmt_byte = high ? {4'h0, r[11:8]} : r[7:0]; // see R20
		end
	endfunction

	// ideal transfer: round to nearest, clamp at full scale
	function automatic adc_seq_pkg::result_t to_code(input adc_seq_pkg::level_t vin,
		input adc_seq_pkg::level_t vref);
		logic [28:0] q;
		q = 29'h0;
		if (vref == 16'h0000) begin
			to_code = `CODE_FULL;
		end else begin
			// twice the ratio plus one, halved: steps move half an lsb down
			q = {vin, 13'h0000} / {13'h0000, vref}; // see R17
			q = (q + 29'h1) >> 1;
			to_code = (q > {17'h0, `CODE_FULL}) ? `CODE_FULL : q[11:0]; // see R16
		end
	endfunction

	// ----------------------------------------
	// input and reference routing
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_chan
			assign chan_v[g] = ext_analog_inputs_in[g*16 +: 16];
			// a pin is switched in only for an external source, codes 0 and 5..7
			assign ext_chan_route_out[g] = adc_power_en_q
				&& src_is_ext(input_src_sel_q)
				&& (ext_chan_sel_q == 4'(g)); // see R7
		end
	endgenerate

	// input mux; a floating channel is modelled as zero
	always_comb begin
		if (input_src_sel_q == `SRC_BANDGAP) begin
			sel_v = bandgap_voltage_in; // see R7
		end else if (!src_is_ext(input_src_sel_q)) begin
			sel_v = 16'h0000; // ground codes
		end else if (ext_chan_sel_q[3]) begin
			sel_v = 16'h0000; // unimplemented channel
		end else begin
			sel_v = chan_v[ext_chan_sel_q[2:0]];
		end
	end

	// reference mux
	assign vref_v = (vref_src_sel_q == `VREF_AVDD) ? avdd_level_in : vref_pin_in; // see R9

	// ----------------------------------------
	// a/d clock prescaler
	// ----------------------------------------
	// held in restart outside a run so each run starts on a clean period
	adc_clk_div u_div (
		.core_clk_in(core_clk_in),
		.resetn_in(resetn_in),
		.enable_in(adc_power_en_q),
		.restart_in(!running),
		.div_sel_in(adc_clk_div_sel_q),
		.tick_out(tick)
	);

	// ----------------------------------------
	// configuration next values
	// ----------------------------------------
	always_comb begin
		ext_chan_sel_d = ext_chan_sel_q;
		adc_power_en_d = adc_power_en_q;
		result_format_sel_d = result_format_sel_q;
		start_d = start_q;
		adc_clk_div_sel_d = adc_clk_div_sel_q;
		input_src_sel_d = input_src_sel_q;
		vref_src_sel_d = vref_src_sel_q;
		conv_irq_en_d = conv_irq_en_q;
		global_irq_en_d = global_irq_en_q;
		// busy bit is read only, write ignores it
		if (wr_first) begin
			ext_chan_sel_d = reg_wdata_in[`F1_CHAN_MSB:`F1_CHAN_LSB];
			adc_power_en_d = reg_wdata_in[`F1_POWER];
			result_format_sel_d = reg_wdata_in[`F1_FORMAT];
			start_d = reg_wdata_in[`F1_START];
		end
		if (reg_wr_in && (reg_addr_in == `ADDR_CTRL_SECOND)) begin
			adc_clk_div_sel_d = reg_wdata_in[`F2_DIV_MSB:`F2_DIV_LSB];
			input_src_sel_d = reg_wdata_in[`F2_SRC_MSB:`F2_SRC_LSB];
			vref_src_sel_d = reg_wdata_in[`F2_VREF_MSB:`F2_VREF_LSB];
		end
		if (wr_irq) begin
			conv_irq_en_d = reg_wdata_in[`FI_CONV_EN];
			global_irq_en_d = reg_wdata_in[`FI_GLOBAL_EN];
		end
	end

	// configuration registers
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			{start_q, result_format_sel_q, adc_power_en_q, ext_chan_sel_q} <= 7'h00;
			{vref_src_sel_q, input_src_sel_q, adc_clk_div_sel_q} <= `RST_CTRL_SECOND;
			conv_irq_en_q <= 1'b0;
			global_irq_en_q <= 1'b0;
		end else begin
			ext_chan_sel_q <= ext_chan_sel_d;
			adc_power_en_q <= adc_power_en_d;
			result_format_sel_q <= result_format_sel_d;
			start_q <= start_d;
			adc_clk_div_sel_q <= adc_clk_div_sel_d;
			input_src_sel_q <= input_src_sel_d;
			vref_src_sel_q <= vref_src_sel_d;
			conv_irq_en_q <= conv_irq_en_d;
			global_irq_en_q <= global_irq_en_d;
		end
	end

	// ----------------------------------------
	// sequencer next values
	// ----------------------------------------
	// runs on its own off the prescaler; software only polls or waits (see R2)
	always_comb begin
		state_d = state_q;
		phase_cnt_d = phase_cnt_q;
		conv_busy_flag_d = conv_busy_flag_q;
		sample_d = sample_q;
		result_d = result_q;
		conv_irq_flag_d = conv_irq_flag_q;
		// software writes the flag; completion below wins over a clear
		if (wr_irq) begin
			conv_irq_flag_d = reg_wdata_in[`FI_FLAG]; // see R14
		end
		if (!adc_power_en_q) begin
			// powered down: nothing runs, no run survives
			state_d = adc_seq_pkg::ST_IDLE; // see R15
			phase_cnt_d = 4'h0;
			conv_busy_flag_d = 1'b0;
		end else if (start_rise) begin
			// rising edge resets the converter; busy left as it was
			state_d = adc_seq_pkg::ST_ARMED; // see R12
			phase_cnt_d = 4'h0; // see R19
		end else if (start_fall && (state_q == adc_seq_pkg::ST_ARMED)) begin
			state_d = adc_seq_pkg::ST_SAMPLE; // see R12
			phase_cnt_d = 4'h0;
			conv_busy_flag_d = 1'b1; // see R13
		end else begin
			case (state_q)
				adc_seq_pkg::ST_IDLE: begin
					phase_cnt_d = 4'h0;
				end
				adc_seq_pkg::ST_ARMED: begin
					phase_cnt_d = 4'h0;
				end
				adc_seq_pkg::ST_SAMPLE: begin
					if (tick && (phase_cnt_q == `SAMPLE_TICKS - 4'h1)) begin
						// hold the input at the end of the sampling window
						sample_d = sel_v;
						phase_cnt_d = 4'h0;
						state_d = adc_seq_pkg::ST_CONVERT; // see R1
					end else if (tick) begin
						phase_cnt_d = phase_cnt_q + 4'h1;
					end
				end
				adc_seq_pkg::ST_CONVERT: begin
					if (done) begin
						result_d = to_code(sample_q, vref_v); // see R16
						state_d = adc_seq_pkg::ST_IDLE; // see R1
						phase_cnt_d = 4'h0;
						conv_busy_flag_d = 1'b0; // see R13
						conv_irq_flag_d = 1'b1; // see R14
					end else if (tick) begin
						phase_cnt_d = phase_cnt_q + 4'h1;
					end
				end
				default: begin
					state_d = adc_seq_pkg::ST_IDLE;
				end
			endcase
		end
		// read port: data valid only in the cycle after the strobe
		rdata_d = 8'h00;
		if (reg_rd_in) begin
			case (reg_addr_in)
				`ADDR_CTRL_FIRST: rdata_d = {start_q, conv_busy_flag_q,
					result_format_sel_q, adc_power_en_q, ext_chan_sel_q};
				`ADDR_CTRL_SECOND: rdata_d = {vref_src_sel_q, input_src_sel_q,
					adc_clk_div_sel_q};
				`ADDR_RES_HIGH: rdata_d = fmt_byte(result_q, result_format_sel_q, 1'b1);
				`ADDR_RES_LOW: rdata_d = fmt_byte(result_q, result_format_sel_q, 1'b0);
				`ADDR_IRQ_CTRL: rdata_d = {5'h00, global_irq_en_q, conv_irq_en_q,
					conv_irq_flag_q};
				default: rdata_d = 8'h00;
			endcase
		end
		// request line seen by the interrupt controller
		irq_req_d = conv_irq_flag_d && conv_irq_en_d && global_irq_en_d;
	end

	// sequencer registers
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_q <= adc_seq_pkg::ST_IDLE;
			phase_cnt_q <= 4'h0;
			conv_busy_flag_q <= 1'b0;
			conv_irq_flag_q <= 1'b0;
			sample_q <= 16'h0000;
			result_q <= 12'h000;
			rdata_q <= 8'h00;
			irq_req_q <= 1'b0;
		end else begin
			state_q <= state_d;
			phase_cnt_q <= phase_cnt_d;
			conv_busy_flag_q <= conv_busy_flag_d;
			conv_irq_flag_q <= conv_irq_flag_d;
			sample_q <= sample_d;
			result_q <= result_d;
			rdata_q <= rdata_d;
			irq_req_q <= irq_req_d;
		end
	end

	assign reg_rdata_out = rdata_q;
	assign conv_busy_flag_out = conv_busy_flag_q;
	assign conv_irq_req_out = irq_req_q;
	assign adc_power_en_out = adc_power_en_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);

	sample_to_conv_a: assert property ( // see R1
		state_q == adc_seq_pkg::ST_SAMPLE && tick && phase_cnt_q == 4'h3
		&& adc_power_en_q && !start_rise |=> state_q == adc_seq_pkg::ST_CONVERT)
		else $error("sampling did not last four a/d clocks");
	conv_to_idle_a: assert property ( // see R1
		state_q == adc_seq_pkg::ST_CONVERT && tick && phase_cnt_q == 4'hb
		&& adc_power_en_q && !start_rise |=> !conv_busy_flag_q && conv_irq_flag_q)
		else $error("conversion did not end after twelve a/d clocks");
	start_fall_run_a: assert property ( // see R12
		state_q == adc_seq_pkg::ST_ARMED && start_fall && adc_power_en_q
		|=> state_q == adc_seq_pkg::ST_SAMPLE && conv_busy_flag_q)
		else $error("falling start did not begin sampling");
	start_rise_arm_a: assert property ( // see R12
		start_rise && adc_power_en_q |=> state_q == adc_seq_pkg::ST_ARMED)
		else $error("rising start did not reset converter");
	restart_busy_a: assert property ( // see R19
		conv_busy_flag_q && start_rise && adc_power_en_q
		|=> conv_busy_flag_q ##1 conv_busy_flag_q)
		else $error("busy dropped on restart");
	busy_end_flag_a: assert property ( // see R13
		$fell(conv_busy_flag_q) && $past(adc_power_en_q)
		|-> conv_irq_flag_q && result_q == $past(result_d))
		else $error("busy fell without flag or result");
	power_off_a: assert property ( // see R15
		!adc_power_en_q |=> state_q == adc_seq_pkg::ST_IDLE && !conv_busy_flag_q)
		else $error("converter active while powered down");
	format_left_a: assert property ( // see R20
		reg_rd_in && reg_addr_in == `ADDR_RES_HIGH && !result_format_sel_q
		|=> reg_rdata_out == $past(result_q[11:4]))
		else $error("left justified high byte wrong");
	vref_route_a: assert property ( // see R9
		state_q == adc_seq_pkg::ST_CONVERT && vref_src_sel_q != 2'h1
		|-> vref_v == vref_pin_in)
		else $error("reference pin not routed");
	bandgap_route_a: assert property ( // see R7
		input_src_sel_q == 3'h1 |-> sel_v == bandgap_voltage_in
		&& ext_chan_route_out == 8'h00)
		else $error("bandgap not routed alone");

	done_c: cover property (conv_busy_flag_q ##1 !conv_busy_flag_q);
	restart_c: cover property (state_q == adc_seq_pkg::ST_CONVERT && start_rise);
	full_c: cover property (done && to_code(sample_q, vref_v) == `CODE_FULL);
	irq_c: cover property ($rose(conv_irq_req_out));
endmodule
`default_nettype wire

// ===== adc_conversion_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.svh"

module adc_conversion_sequencer_tb;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic rstn = 1'b0; // active low, held 20 cycles
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [127:0] ext = '0; // eight 16-bit channel levels
	logic [15:0] bg = 16'h0000;
	logic [15:0] avdd = 16'h0000;
	logic [15:0] vpin = 16'h0000;
	logic [7:0] rdata;
	logic [7:0] route;
	logic busy;
	logic irq;
	logic pwr;
	logic [7:0] d;
	integer n_mismatch = 0;
	integer comparisons = 0;
	int exp_q[$]; // model codes, queued at each start
	int src_tab[8] = '{0, 5, 6, 7, 1, 2, 3, 4};
	int vin_tab[6] = '{0, 1, 8188, 8189, 8192, 65535};
	logic [7:0] irq_wr[4] = '{8'h03, 8'h05, 8'h07, 8'h06};
	logic irq_exp[4] = '{1'b0, 1'b0, 1'b1, 1'b0};

	adc_conversion_sequencer u_adc_conversion_sequencer (
		.core_clk_in(clk),
		.resetn_in(rstn),
		.reg_addr_in(addr),
		.reg_wdata_in(wdata),
		.reg_wr_in(wr),
		.reg_rd_in(rd),
		.reg_rdata_out(rdata),
		.ext_analog_inputs_in(ext),
		.bandgap_voltage_in(bg),
		.avdd_level_in(avdd),
		.vref_pin_in(vpin),
		.ext_chan_route_out(route),
		.conv_busy_flag_out(busy),
		.conv_irq_req_out(irq),
		.adc_power_en_out(pwr)
	);

	// 20 mhz core clock
	initial begin
		forever #25 clk = ~clk;
	end

	// ----------------------------------------
	// reporting
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ----------------------------------------
	// register bus, one-cycle strobes
	// ----------------------------------------
	// a gap cycle follows every strobe so no signal is set twice in a step
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe edge
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	// ----------------------------------------
	// behavioural model
	// ----------------------------------------
	// half-step offset equals rounding to nearest, ties upward
	function automatic int code_of(input int vin, input int vref);
		int c;
		if (vref == 0) return 4095;
		c = (2 * vin * 4096 + vref) / (2 * vref);
		return (c > 4095) ? 4095 : c;
	endfunction

	function automatic int vin_of(input int ch, input int src);
		if (src == 1) return int'(bg);
		if (src >= 2 && src <= 4) return 0; // grounded sources
		return (ch < 8) ? int'(ext[16 * ch +: 16]) : 0; // floating reads zero
	endfunction

	function automatic logic [7:0] route_of(input int ch, input int src, input int p);
		if (p != 0 && (src == 0 || src >= 5) && ch < 8) return 8'h01 << ch;
		return 8'h00;
	endfunction

	// ----------------------------------------
	// conversion helpers
	// ----------------------------------------
	// start bit low-high-low; optional busy look between rise and fall
	task automatic start_conv(input logic [7:0] c0, input logic chk);
		wr_reg(`ADDR_CTRL_FIRST, c0 | 8'h80);
		if (chk) begin
			#1 check(16'(busy), 16'h0001);
		end
		wr_reg(`ADDR_CTRL_FIRST, c0 & 8'h7f);
		#1;
	endtask

	// counts busy cycles; a hang ends in the closing report
	task automatic run_len(input int want);
		int n;
		n = 0;
		while (busy === 1'b1 && n < 5000) begin
			@(posedge clk);
			#1 n++;
		end
		check(16'(n), 16'(want));
		if (n >= 5000) report_and_stop();
	endtask

	task automatic convert(input int ch, input int src, input int vs, input int dv, input int fmt);
		logic [7:0] hi;
		logic [7:0] lo;
		logic [7:0] fl;
		int code;
		wr_reg(`ADDR_CTRL_FIRST, {2'b00, fmt[0], 1'b1, ch[3:0]});
		wr_reg(`ADDR_CTRL_SECOND, {vs[1:0], src[2:0], dv[2:0]});
		wr_reg(`ADDR_IRQ_CTRL, 8'h06);
		exp_q.push_back(code_of(vin_of(ch, src), (vs == 1) ? int'(avdd) : int'(vpin)));
		start_conv({2'b00, fmt[0], 1'b1, ch[3:0]}, 1'b0);
		check(16'(route), 16'(route_of(ch, src, 1)));
		run_len(16 << dv);
		check(16'(irq), 16'h0001);
		rd_reg(`ADDR_RES_HIGH, hi);
		rd_reg(`ADDR_RES_LOW, lo);
		rd_reg(`ADDR_IRQ_CTRL, fl);
		code = exp_q.pop_front();
		check({hi, lo}, (fmt != 0) ? 16'(code) : 16'(code) << 4);
		check(16'(fl), 16'h0007);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(51738));
		for (int i = 0; i < 8; i++) ext[16 * i +: 16] <= 16'($urandom_range(16'h7fff));
		bg <= 16'($urandom_range(16'h7fff));
		avdd <= 16'h8000 | 16'($urandom_range(16'h7fff));
		vpin <= 16'h8000 | 16'($urandom_range(16'h7fff));
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		// every register, mapped or not, reads zero out of reset
		for (int a = 0; a < 8; a++) begin
			rd_reg(3'(a), d);
			check(16'(d), 16'h0000);
		end
		check({route, busy, irq, pwr}, 16'h0000);
		$display("test reset finished");
		// read-only places and unmapped addresses ignore writes
		wr_reg(`ADDR_RES_HIGH, 8'hff);
		wr_reg(3'h5, 8'hff);
		wr_reg(`ADDR_CTRL_FIRST, 8'h40);
		rd_reg(`ADDR_RES_HIGH, d);
		check(16'(d), 16'h0000);
		rd_reg(3'h5, d);
		check(16'(d), 16'h0000);
		rd_reg(`ADDR_CTRL_FIRST, d);
		check(16'(d), 16'h0000);
		$display("test read_only finished");
		// every divider and source code once, each reference code twice, each format four times
		for (int i = 0; i < 8; i++) begin
			convert((i < 3) ? $urandom_range(7) : 8 + $urandom_range(7), src_tab[i], i % 4, i, i % 2);
		end
		$display("test divider_sweep finished");
		// transfer edges: one step is two units at this reference
		@(posedge clk);
		vpin <= 16'h2000;
		foreach (vin_tab[k]) begin
			@(posedge clk);
			ext[15:0] <= 16'(vin_tab[k]);
			convert(0, 0, 0, 0, k % 2);
		end
		$display("test transfer finished");
		// routing per source, then with power off
		for (int s = 0; s < 8; s++) begin
			int ch;
			ch = (s >= 1 && s <= 4) ? 8 + $urandom_range(7) : $urandom_range(7);
			wr_reg(`ADDR_CTRL_FIRST, {4'h1, 4'(ch)});
			wr_reg(`ADDR_CTRL_SECOND, {5'(s), 3'h0});
			#1 check(16'(route), 16'(route_of(ch, s, 1)));
			wr_reg(`ADDR_CTRL_FIRST, {4'h0, 4'(ch)});
			#1 check(16'(route), 16'h0000);
		end
		$display("test routing finished");
		// request is flag and both enables
		foreach (irq_wr[k]) begin
			wr_reg(`ADDR_IRQ_CTRL, irq_wr[k]);
			@(posedge clk);
			#1 check(16'(irq), 16'(irq_exp[k]));
		end
		$display("test irq_mask finished");
		// restart mid-run keeps busy and times a fresh full run
		wr_reg(`ADDR_CTRL_SECOND, 8'h02);
		wr_reg(`ADDR_CTRL_FIRST, 8'h10);
		start_conv(8'h10, 1'b0);
		repeat (30) @(posedge clk);
		rd_reg(`ADDR_CTRL_FIRST, d);
		check(16'(d), 16'h0050);
		start_conv(8'h10, 1'b1);
		run_len(64);
		$display("test restart finished");
		// power off mid-run: idle, no flag, later starts ignored
		wr_reg(`ADDR_IRQ_CTRL, 8'h06);
		start_conv(8'h10, 1'b0);
		check(16'(pwr), 16'h0001);
		repeat (20) @(posedge clk);
		wr_reg(`ADDR_CTRL_FIRST, 8'h00);
		repeat (2) @(posedge clk);
		#1 check({busy, pwr}, 16'h0000);
		start_conv(8'h00, 1'b0);
		repeat (80) @(posedge clk);
		#1 check({busy, irq}, 16'h0000);
		rd_reg(`ADDR_IRQ_CTRL, d);
		check(16'(d), 16'h0006);
		$display("test power_off finished");
		report_and_stop();
	end
endmodule
`default_nettype wire

// ===== adc_seq_map.svh
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_CTRL_FIRST 3'h0
`define ADDR_CTRL_SECOND 3'h1
`define ADDR_RES_HIGH 3'h2
`define ADDR_RES_LOW 3'h3
`define ADDR_IRQ_CTRL 3'h4

// ----------------------------------------
// first control register fields
// ----------------------------------------
`define F1_CHAN_LSB 0
`define F1_CHAN_MSB 3
`define F1_POWER 4
`define F1_FORMAT 5
`define F1_BUSY 6
`define F1_START 7

// ----------------------------------------
// second control register fields
// ----------------------------------------
`define F2_DIV_LSB 0
`define F2_DIV_MSB 2
`define F2_SRC_LSB 3
`define F2_SRC_MSB 5
`define F2_VREF_LSB 6
`define F2_VREF_MSB 7

// ----------------------------------------
// interrupt control register fields
// ----------------------------------------
`define FI_FLAG 0
`define FI_CONV_EN 1
`define FI_GLOBAL_EN 2

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define RST_CTRL_FIRST 8'h00
`define RST_CTRL_SECOND 8'h00
`define RST_IRQ_CTRL 8'h00
`define SRC_BANDGAP 3'h1
`define VREF_AVDD 2'h1
`define CODE_FULL 12'hfff

// ----------------------------------------
// timing in a/d clock periods
// ----------------------------------------
`define SAMPLE_TICKS 4'h4
`define CONV_TICKS 4'hc
`define TOTAL_TICKS 5'h10

`endif

// ===== adc_seq_pkg.sv
`default_nettype none
package adc_seq_pkg;
	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARMED,
		ST_SAMPLE,
		ST_CONVERT
	} conv_state_e;
	// 12-bit conversion code
	typedef logic [11:0] result_t;
	// analog level, arbitrary linear unit
	typedef logic [15:0] level_t;
endpackage
`default_nettype wire
